/* design/regulator_control_registers.sv */
/*
  byte-wide control and status registers for buck2, buck3 and ldo4, with the
  decoded control levels driven to the analog regulators.
  assumes a serial interface front end presents byte accesses as a one-cycle
  write strobe or read strobe with an 8-bit address, synchronous to clk.
*/
// Contract
// - voltage select pin high applies the secondary six-bit voltage code.
// - voltage select pin low applies the primary six-bit voltage code.
// - control bit 7 set turns regulator on, clear turns it off.
// - buck2 control bit 6 set runs 180 degrees out of phase.
// - step-down bit 5 set forces PWM; clear allows power-saving at light load.
// - control bits 4 to 2 hold a read/write turn-on delay code.
// - control bit 1 set lets a regulator fault raise an interrupt.
// - control bit 0 reads power-good status, read-only.
// - linear regulator has one six-bit voltage code, independent of select pin.
// - ldo bit 6 set discharges output through resistor while shut down.
// - ldo bit 5 set selects low-power mode, clear normal mode.
`timescale 1ns/1ps
`include "regctl_defines.svh"
module regulator_control_registers
  import regctl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic voltage_select_pin,
  input wire logic buck2_power_good,
  input wire logic buck3_power_good,
  input wire logic ldo4_power_good,
  input wire logic buck2_fault,
  input wire logic buck3_fault,
  input wire logic ldo4_fault,
  input wire logic [5:0] buck2_primary_voltage_code,
  output logic [5:0] buck2_vout_setting,
  output logic [5:0] buck3_vout_setting,
  output logic [5:0] ldo4_vout_setting,
  output logic buck2_enable,
  output logic buck3_enable,
  output logic ldo4_enable,
  output logic buck2_phase_shift,
  output logic buck2_forced_pwm,
  output logic buck3_forced_pwm,
  output logic ldo4_discharge,
  output logic ldo4_low_quiescent_mode,
  output logic [2:0] buck2_delay_code,
  output logic [2:0] buck3_delay_code,
  output logic [2:0] ldo4_delay_code,
  output logic fault_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for pins
  logic select_s;
  logic [2:0] pg_s;
  logic [2:0] flt_s;

  select_pin_sync u_select (
    .clk(clk),
    .nrst(nrst),
    .pin_in(voltage_select_pin),
    .pin_sync(select_s)
  );

  logic [5:0] pin_meta_r;
  logic [5:0] pin_sync_r;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_meta_r <= 6'h00;
      pin_sync_r <= 6'h00;
    end else begin
      pin_meta_r <= {ldo4_fault, buck3_fault, buck2_fault, ldo4_power_good, buck3_power_good, buck2_power_good};
      pin_sync_r <= pin_meta_r;
    end
  end
  assign pg_s = pin_sync_r[2:0];
  assign flt_s = pin_sync_r[5:3];

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  vout_code_t buck2_high_r;
  vout_code_t buck3_low_r;
  vout_code_t buck3_high_r;
  vout_code_t ldo4_code_r;
  logic [6:0] buck2_ctl_r;
  logic [6:0] buck3_ctl_r;
  logic [6:0] ldo4_ctl_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // one write strobe per register keeps each store a plain enable
  logic wr_buck2_high;
  logic wr_buck2_ctl;
  logic wr_buck3_low;
  logic wr_buck3_high;
  logic wr_buck3_ctl;
  logic wr_ldo4_code;
  logic wr_ldo4_ctl;

  assign wr_buck2_high = wr_stb & hit(addr, `OFS_BUCK2_VOUT_HIGH);
  assign wr_buck2_ctl = wr_stb & hit(addr, `OFS_BUCK2_CONTROL);
  assign wr_buck3_low = wr_stb & hit(addr, `OFS_BUCK3_VOUT_LOW);
  assign wr_buck3_high = wr_stb & hit(addr, `OFS_BUCK3_VOUT_HIGH);
  assign wr_buck3_ctl = wr_stb & hit(addr, `OFS_BUCK3_CONTROL);
  assign wr_ldo4_code = wr_stb & hit(addr, `OFS_LDO4_VOUT);
  assign wr_ldo4_ctl = wr_stb & hit(addr, `OFS_LDO4_CONTROL);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      buck2_high_r <= `RST_VOUT_CODE;
      buck3_low_r <= `RST_VOUT_CODE;
      buck3_high_r <= `RST_VOUT_CODE;
      ldo4_code_r <= `RST_VOUT_CODE;
    end else begin
      if (wr_buck2_high) buck2_high_r <= wdata[5:0];
      if (wr_buck3_low) buck3_low_r <= wdata[5:0];
      if (wr_buck3_high) buck3_high_r <= wdata[5:0];
      if (wr_ldo4_code) ldo4_code_r <= wdata[5:0];
    end
  end

  // control bits 7..1 stored, except buck3 bit 6 which is written as zero; bit 0 is status only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      buck2_ctl_r <= `RST_CONTROL;
      buck3_ctl_r <= `RST_CONTROL;
      ldo4_ctl_r <= `RST_CONTROL;
    end else begin
      if (wr_buck2_ctl) buck2_ctl_r <= wdata[7:1];
      if (wr_buck3_ctl) buck3_ctl_r <= {wdata[7], 1'b0, wdata[5:1]};
      if (wr_ldo4_ctl) ldo4_ctl_r <= wdata[7:1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  function automatic reg_byte_t code_byte(input vout_code_t c);
    code_byte = {2'h0, c};
  endfunction : code_byte

  // status bit 0 is spliced in live; the stored part holds bits 7..1
  function automatic reg_byte_t ctl_byte(input logic [6:0] c, input logic pg);
    ctl_byte = {c, pg};
  endfunction : ctl_byte

  reg_byte_t rdata_nxt;
  always_comb begin
    rdata_nxt = 8'h00;
    case (addr)
      `OFS_BUCK2_VOUT_HIGH: rdata_nxt = code_byte(buck2_high_r);
      `OFS_BUCK2_CONTROL: rdata_nxt = ctl_byte(buck2_ctl_r, pg_s[0]);
      `OFS_BUCK3_VOUT_LOW: rdata_nxt = code_byte(buck3_low_r);
      `OFS_BUCK3_VOUT_HIGH: rdata_nxt = code_byte(buck3_high_r);
      `OFS_BUCK3_CONTROL: rdata_nxt = ctl_byte(buck3_ctl_r, pg_s[1]);
      `OFS_LDO4_VOUT: rdata_nxt = code_byte(ldo4_code_r);
      `OFS_LDO4_CONTROL: rdata_nxt = ctl_byte(ldo4_ctl_r, pg_s[2]);
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_stb;
      if (rd_stb) rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      buck2_vout_setting <= `RST_VOUT_CODE;
      buck3_vout_setting <= `RST_VOUT_CODE;
      ldo4_vout_setting <= `RST_VOUT_CODE;
    end else begin
      buck2_vout_setting <= select_s ? buck2_high_r : buck2_primary_voltage_code;
      buck3_vout_setting <= select_s ? buck3_high_r : buck3_low_r;
      ldo4_vout_setting <= ldo4_code_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      buck2_enable <= 1'b0;
      buck3_enable <= 1'b0;
      ldo4_enable <= 1'b0;
      buck2_phase_shift <= 1'b0;
      buck2_forced_pwm <= 1'b0;
      buck3_forced_pwm <= 1'b0;
      ldo4_discharge <= 1'b0;
      ldo4_low_quiescent_mode <= 1'b0;
      buck2_delay_code <= 3'h0;
      buck3_delay_code <= 3'h0;
      ldo4_delay_code <= 3'h0;
    end else begin
      buck2_enable <= buck2_ctl_r[`BIT_ENABLE-1];
      buck3_enable <= buck3_ctl_r[`BIT_ENABLE-1];
      ldo4_enable <= ldo4_ctl_r[`BIT_ENABLE-1];
      buck2_phase_shift <= buck2_ctl_r[`BIT_PHASE-1];
      buck2_forced_pwm <= buck2_ctl_r[`BIT_MODE-1];
      buck3_forced_pwm <= buck3_ctl_r[`BIT_MODE-1];
      ldo4_discharge <= ldo4_ctl_r[`BIT_DISCHARGE-1] & ~ldo4_ctl_r[`BIT_ENABLE-1];
      ldo4_low_quiescent_mode <= ldo4_ctl_r[`BIT_LOW_QUIESCENT-1];
      buck2_delay_code <= buck2_ctl_r[`BIT_DELAY_HI-1:`BIT_DELAY_LO-1];
      buck3_delay_code <= buck3_ctl_r[`BIT_DELAY_HI-1:`BIT_DELAY_LO-1];
      ldo4_delay_code <= ldo4_ctl_r[`BIT_DELAY_HI-1:`BIT_DELAY_LO-1];
    end
  end

  // fault interrupt gated per regulator
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fault_irq <= 1'b0;
    end else begin
      fault_irq <= (flt_s[0] & buck2_ctl_r[`BIT_FAULT_EN-1]) |
                   (flt_s[1] & buck3_ctl_r[`BIT_FAULT_EN-1]) |
                   (flt_s[2] & ldo4_ctl_r[`BIT_FAULT_EN-1]);
    end
  end

endmodule : regulator_control_registers

/* design/regctl_defines.svh */
/*
  constants of the regulator control register bank: offsets, field positions, reset values.
  assumes inclusion by bare name from design files.
*/
`ifndef REGCTL_DEFINES_SVH
`define REGCTL_DEFINES_SVH

`define OFS_BUCK2_VOUT_HIGH 8'h31
`define OFS_BUCK2_CONTROL 8'h32
`define OFS_BUCK3_VOUT_LOW 8'h40
`define OFS_BUCK3_VOUT_HIGH 8'h41
`define OFS_BUCK3_CONTROL 8'h42
`define OFS_LDO4_VOUT 8'h50
`define OFS_LDO4_CONTROL 8'h51

`define BIT_ENABLE 7
`define BIT_PHASE 6
`define BIT_DISCHARGE 6
`define BIT_MODE 5
`define BIT_LOW_QUIESCENT 5
`define BIT_DELAY_HI 4
`define BIT_DELAY_LO 2
`define BIT_FAULT_EN 1
`define BIT_POWER_GOOD 0

`define RST_VOUT_CODE 6'h00
`define RST_CONTROL 7'h00

`endif

/* design/regctl_pkg.sv */
/*
  types shared by the regulator control register bank.
  assumes nothing of its surroundings.
*/
package regctl_pkg;
  typedef logic [5:0] vout_code_t;
  typedef logic [2:0] delay_code_t;
  typedef logic [7:0] reg_byte_t;
endpackage : regctl_pkg

/* design/voltage_select_pin_sync.sv */
/*
  two flip-flop synchroniser for the external voltage select pin.
  assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ps
module select_pin_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin_in,
  output logic pin_sync
);
  logic meta_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      meta_r <= pin_in;
      pin_sync <= meta_r;
    end
  end
endmodule : select_pin_sync

/* tb/regctl_properties.sv */
/* port checker of the regulator register bank.
   assumes binding onto regulator_control_registers. */
`timescale 1ns/1ps
module regctl_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic buck2_enable,
  input wire logic buck2_phase_shift,
  input wire logic ldo4_enable,
  input wire logic ldo4_discharge,
  input wire logic ldo4_low_quiescent_mode,
  input wire logic [2:0] buck3_delay_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence wr_to(logic [7:0] a);
    wr_stb && addr == a;
  endsequence
  sequence rd_of(logic [7:0] a);
    rd_stb && addr == a;
  endsequence
  a_read_valid_pulse: assert property (rd_stb |=> rvalid) else $error("no read answer");
  a_unmapped_read_zero: assert property (rd_of(8'h33) |=> rdata == 8'h00) else $error("unmapped read");
  a_reserved_bits_zero: assert property (rd_stb && addr inside {8'h31, 8'h40, 8'h41, 8'h50} |=> rdata[7:6] == 2'b00)
    else $error("reserved bits set");
  a_no_phase_bit: assert property (rd_of(8'h42) |=> rdata[6] == 1'b0) else $error("buck3 bit 6 set");
  a_enable_follows_write: assert property (wr_to(8'h32) |=> ##1 buck2_enable == $past(wdata[7], 2))
    else $error("enable wrong");
  a_phase_follows_write: assert property (wr_to(8'h32) |=> ##1 buck2_phase_shift == $past(wdata[6], 2))
    else $error("phase wrong");
  a_delay_follows_write: assert property (wr_to(8'h42) |=> ##1 buck3_delay_code == $past(wdata[4:2], 2))
    else $error("delay wrong");
  a_quiescent_follows_write: assert property (wr_to(8'h51) |=> ##1 ldo4_low_quiescent_mode == $past(wdata[5], 2))
    else $error("low power mode wrong");
  a_discharge_follows_write: assert property (wr_to(8'h51) |=> ##1 ldo4_discharge ==
    ($past(wdata[6], 2) && !$past(wdata[7], 2))) else $error("discharge wrong");
  a_discharge_only_off: assert property (ldo4_discharge |-> !ldo4_enable) else $error("discharge while on");
endmodule : regctl_properties
bind regulator_control_registers regctl_properties u_props (.clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb,
  .rdata, .rvalid, .buck2_enable, .buck2_phase_shift, .ldo4_enable, .ldo4_discharge, .ldo4_low_quiescent_mode,
  .buck3_delay_code);

/* tb/reg_host.sv */
/* host model issuing one-cycle byte accesses.
   assumes strobes are taken at the rising edge of clk. */
`timescale 1ns/1ps
module reg_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr_stb,
  output logic rd_stb
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~v;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    v = 'x;
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    for (int n = 0; n < 4; n++) begin
      #1;
      if (rvalid === 1'b1) begin
        v = rdata;
        break;
      end
      @(posedge clk);
    end
  endtask : rd
endmodule : reg_host

/* tb/regulator_control_registers_tb.sv */
/* self-checking bench of the regulator register bank.
   assumes host model and checker compiled first. */
`timescale 1ns/1ps
module regulator_control_registers_tb;
  import regctl_pkg::*;
  logic clk, nrst, wr_stb, rd_stb, rvalid, voltage_select_pin, fault_irq;
  logic buck2_power_good, buck3_power_good, ldo4_power_good, buck2_fault, buck3_fault, ldo4_fault;
  logic buck2_enable, buck3_enable, ldo4_enable, buck2_phase_shift, buck2_forced_pwm, buck3_forced_pwm;
  logic ldo4_discharge, ldo4_low_quiescent_mode;
  reg_byte_t addr, wdata, rdata, d;
  vout_code_t buck2_primary_voltage_code, buck2_vout_setting, buck3_vout_setting, ldo4_vout_setting;
  delay_code_t buck2_delay_code, buck3_delay_code, ldo4_delay_code;
  int err_count, n_checks;
  reg_byte_t ofs[7] = '{8'h31, 8'h32, 8'h40, 8'h41, 8'h42, 8'h50, 8'h51};
  reg_byte_t full[7] = '{8'h3f, 8'hff, 8'h3f, 8'h3f, 8'hbf, 8'h3f, 8'hff};
  reg_host host (.clk, .rdata, .rvalid, .addr, .wdata, .wr_stb, .rd_stb);
  regulator_control_registers dut (.clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .rvalid,
    .voltage_select_pin, .buck2_power_good, .buck3_power_good, .ldo4_power_good, .buck2_fault, .buck3_fault,
    .ldo4_fault, .buck2_primary_voltage_code, .buck2_vout_setting, .buck3_vout_setting, .ldo4_vout_setting,
    .buck2_enable, .buck3_enable, .ldo4_enable, .buck2_phase_shift, .buck2_forced_pwm, .buck3_forced_pwm,
    .ldo4_discharge, .ldo4_low_quiescent_mode, .buck2_delay_code, .buck3_delay_code, .ldo4_delay_code, .fault_irq);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d);
    chk("read data", exp, d);
  endtask : rchk
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    {nrst, voltage_select_pin, buck2_power_good, buck3_power_good, ldo4_power_good} = 5'h00;
    {buck2_fault, buck3_fault, ldo4_fault} = 3'h0;
    buck2_primary_voltage_code = 6'h0c;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) rchk(ofs[i], 8'h00);
    $display("test reset done");
    @(posedge clk) {buck2_power_good, buck3_power_good, ldo4_power_good} <= 3'h7;
    for (int i = 0; i < 7; i++) host.wr(ofs[i], 8'hff);
    for (int i = 0; i < 7; i++) rchk(ofs[i], full[i]);
    chk("buck2 ctl", 8'h3f, {2'b00, buck2_enable, buck2_phase_shift, buck2_forced_pwm, buck2_delay_code});
    chk("buck3 ctl", 8'h1f, {3'b000, buck3_enable, buck3_forced_pwm, buck3_delay_code});
    chk("ldo4 ctl", 8'h2f, {2'b00, ldo4_enable, ldo4_discharge, ldo4_low_quiescent_mode, ldo4_delay_code});
    $display("test fields done");
    host.wr(8'h32, 8'h52);
    settle();
    chk("buck2 pattern", 8'h14, {2'b00, buck2_enable, buck2_phase_shift, buck2_forced_pwm, buck2_delay_code});
    rchk(8'h32, 8'h53);
    $display("test pattern done");
    host.wr(8'h40, 8'h15);
    host.wr(8'h41, 8'h2a);
    settle();
    chk("buck3 low", 8'h15, {2'b00, buck3_vout_setting});
    chk("buck2 low", 8'h0c, {2'b00, buck2_vout_setting});
    @(posedge clk) voltage_select_pin <= 1'b1;
    settle();
    chk("buck3 high", 8'h2a, {2'b00, buck3_vout_setting});
    chk("buck2 high", 8'h3f, {2'b00, buck2_vout_setting});
    chk("ldo4 code", 8'h3f, {2'b00, ldo4_vout_setting});
    $display("test select done");
    host.wr(8'h51, 8'h40);
    settle();
    chk("ldo4 off", 8'h01, {6'h00, ldo4_enable, ldo4_discharge});
    chk("ldo4 fields", 8'h10, {2'b00, ldo4_enable, ldo4_discharge, ldo4_low_quiescent_mode, ldo4_delay_code});
    @(posedge clk) ldo4_power_good <= 1'b0;
    settle();
    rchk(8'h51, 8'h40);
    @(posedge clk) buck3_fault <= 1'b1;
    settle();
    chk("irq on", 8'h01, {7'h00, fault_irq});
    host.wr(8'h42, 8'h80);
    settle();
    chk("irq masked", 8'h00, {7'h00, fault_irq});
    rchk(8'h42, 8'h81);
    host.wr(8'h33, 8'hff);
    rchk(8'h33, 8'h00);
    $display("test fault done");
    wrap_up();
  end
  initial begin
    repeat (1000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule : regulator_control_registers_tb
